// file: rcf_pkg.sv
/*
  Constants, field layouts and carrier types of the rate-of-change-of-
  frequency stage: time base, setting ranges, register offsets, states.
  Assumes a 10 MHz system clock and a 10 ms measurement interval.
*/
`default_nettype none
package rcf_pkg;

  // Clock and measurement time base
  localparam int CLK_NS = 100;
  localparam int TICK_MS = 10;
  localparam int TICK_NS = TICK_MS * 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  // Stage timing, in ms and in whole intervals
  localparam int PICKUP_MS = 80;
  localparam int START_MS = 60;
  localparam int STABLE_MS = 80;
  localparam int DLY_STEP_MS = 20;
  localparam logic [3:0] PICKUP_TICKS = 4'(PICKUP_MS / TICK_MS);
  localparam logic [3:0] START_TICKS = 4'(START_MS / TICK_MS);
  localparam logic [3:0] STABLE_TICKS = 4'(STABLE_MS / TICK_MS);
  localparam logic [9:0] DLY_TICK_MUL = 10'(DLY_STEP_MS / TICK_MS);

  // Evaluation interval choices of the programmable stages
  localparam int EVAL_S_MS = 10;
  localparam int EVAL_M_MS = 20;
  localparam int EVAL_L_MS = 100;
  localparam logic [3:0] EVAL_DIV_S = 4'(EVAL_S_MS / TICK_MS);
  localparam logic [3:0] EVAL_DIV_M = 4'(EVAL_M_MS / TICK_MS);
  localparam logic [3:0] EVAL_DIV_L = 4'(EVAL_L_MS / TICK_MS);

  // Setting ranges (threshold 0.1 Hz/s, delays 20 ms) and defaults
  localparam logic [6:0] THR_MIN = 7'h02;
  localparam logic [6:0] THR_MAX = 7'h64;
  localparam logic [8:0] DLY_MAX = 9'h1F4;
  localparam logic [6:0] THR_RST = 7'h05;
  localparam logic [8:0] DLY_RST = 9'h01E;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PROG = 8'h08;
  localparam logic [3:0] GRP_PAGE = 4'h1;

  // Field positions
  localparam int CTRL_GRP = 0;
  localparam int CTRL_EVAL = 2;
  localparam int CTRL_LATCH = 4;
  localparam int CTRL_STORE = 6;
  localparam int CTRL_REL = 7;
  localparam int GRP_THR = 0;
  localparam int GRP_TOP = 8;
  localparam int GRP_TMIN = 20;
  localparam int PROG_MODE = 0;
  localparam int PROG_SEL_A = 2;
  localparam int PROG_SEL_B = 7;
  localparam int STAT_STATE = 0;
  localparam int STAT_START = 2;
  localparam int STAT_TRIP = 3;
  localparam int STAT_LATCH = 4;
  localparam int STAT_LV = 6;
  localparam int STAT_DEP = 7;
  localparam int STAT_GRP = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARM = 2'h1,
    ST_RUN = 2'h3,
    ST_DONE = 2'h2
  } rcf_state_e;

  typedef enum logic [1:0] {
    PM_OVER = 2'h0,
    PM_UNDER = 2'h1,
    PM_DIFF = 2'h2,
    PM_MAGDIFF = 2'h3
  } rcf_mode_e;

  typedef struct packed {
    logic [6:0] thr;
    logic [8:0] top;
    logic [8:0] tmin;
  } rcf_grp_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rcf_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcf_apb_rsp_s;

  typedef struct packed {
    logic store_en;
    logic [1:0] kept;
    logic restore;
    logic [1:0] grp;
    logic [1:0] eval_sel;
    logic [1:0] latch_en;
    rcf_mode_e mode;
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    rcf_grp_s [3:0] set;
    logic [16:0] tick_cnt;
    logic [3:0] eval_cnt;
    logic eval_tick;
    logic [16:0] prev_freq;
    logic have_prev;
    logic [16:0] start_freq;
    rcf_state_e st;
    logic [3:0] cnt;
    logic [10:0] n;
    logic start_out;
    logic trip;
    logic [1:0] latched;
    logic [1:0] contacts;
    logic [31:0] prdata;
  } rcf_regs_s;

  localparam rcf_grp_s GRP_RST = '{
    thr: THR_RST,
    top: DLY_RST,
    tmin: DLY_RST
  };

  localparam rcf_regs_s REGS_RST = '{
    set: {4{GRP_RST}},
    restore: 1'b1,
    mode: PM_OVER,
    st: ST_IDLE,
    default: '0
  };

endpackage
`default_nettype wire

// file: rcf_stage.sv
/*
  Rate-of-change-of-frequency protection stage with four setting groups,
  output latching with restore after restart, and an APB register slave.
  Assumes freq_mhz, lv_block and release_req come from logic on clk;
  por clears everything, rst is a device restart that keeps the stored
  latch states. The measurement interval is TICK_CYCLES clocks; all
  stage delays are whole intervals, so timing resolution is one tick.
  Group settings return to defaults on restart; only the latch copy
  and the store enable survive, since the rest of the bank is not retained.

*/
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rcf_stage #(
  parameter int TICK_CYCLES = rcf_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire rcf_pkg::rcf_apb_req_s apb_req,
  output var rcf_pkg::rcf_apb_rsp_s apb_rsp,
  input wire logic [16:0] freq_mhz,
  input wire logic lv_block,
  input wire logic release_req,
  output var logic [1:0] output_contacts,
  output var logic eval_tick,
  output var rcf_pkg::rcf_mode_e prog_mode,
  output var logic [4:0] prog_sel_a,
  output var logic [4:0] prog_sel_b
);
  import rcf_pkg::*;

  // Registered state and its next value
  rcf_regs_s r;
  rcf_regs_s next_r;

  // Active and incoming group settings
  rcf_grp_s cur;
  rcf_grp_s wgrp;
  logic mapped;
  logic is_grp;
  logic diff_mode;
  logic [31:0] rd;

  // Strobes derived each cycle
  logic tick;
  logic wr;
  logic rel;
  logic clr;
  logic above;
  logic trip_ok;

  // Slope and average arithmetic, in mHz and ticks
  logic [17:0] delta;
  logic [17:0] acc;
  logic [16:0] mag;
  logic [16:0] acc_mag;
  logic [16:0] lim;
  logic [9:0] top_t;
  logic [9:0] tmin_t;
  logic [10:0] n_inc;
  logic [3:0] div;
  logic [1:0] live;

  // Second coupling only meaningful in the difference modes
  assign diff_mode = (r.mode == PM_DIFF) || (r.mode == PM_MAGDIFF);

  // Address decode and read data
  // Unaligned or unlisted words fall to the default, unmapped
  always_comb
  begin
    mapped = 1'b0;
    rd = 32'h0000_0000;
    is_grp = (apb_req.paddr[7:4] == GRP_PAGE)
      && (apb_req.paddr[1:0] == 2'h0);
    case (apb_req.paddr)
      OFS_CTRL:
      begin
        mapped = 1'b1;
        rd[CTRL_GRP +: 2] = r.grp;
        rd[CTRL_EVAL +: 2] = r.eval_sel;
        rd[CTRL_LATCH +: 2] = r.latch_en;
        rd[CTRL_STORE] = r.store_en;
      end
      OFS_STATUS:
      begin
        mapped = 1'b1;
        rd[STAT_STATE +: 2] = r.st;
        rd[STAT_START] = r.start_out;
        rd[STAT_TRIP] = r.trip;
        rd[STAT_LATCH +: 2] = r.latched;
        rd[STAT_LV] = lv_block;
        rd[STAT_DEP] = cur.tmin < cur.top;
        rd[STAT_GRP +: 2] = r.grp;
      end
      OFS_PROG:
      begin
        mapped = 1'b1;
        rd[PROG_MODE +: 2] = r.mode;
        rd[PROG_SEL_A +: 5] = r.sel_a;
        rd[PROG_SEL_B +: 5] = diff_mode ? r.sel_b : 5'h00;
      end
      default:
      begin
        if (is_grp)
        begin
          mapped = 1'b1;
          rd[GRP_THR +: 7] = r.set[apb_req.paddr[3:2]].thr;
          rd[GRP_TOP +: 9] = r.set[apb_req.paddr[3:2]].top;
          rd[GRP_TMIN +: 9] = r.set[apb_req.paddr[3:2]].tmin;
        end
      end
    endcase
  end

  // Clamped group write value
  // Out-of-range settings saturate instead of being refused
  always_comb
  begin
    wgrp.thr = apb_req.pwdata[GRP_THR +: 7];
    wgrp.top = apb_req.pwdata[GRP_TOP +: 9];
    wgrp.tmin = apb_req.pwdata[GRP_TMIN +: 9];
    if (wgrp.thr < THR_MIN)
      wgrp.thr = THR_MIN;
    else if (wgrp.thr > THR_MAX)
      wgrp.thr = THR_MAX;
    if (wgrp.top > DLY_MAX)
      wgrp.top = DLY_MAX;
    if (wgrp.tmin > DLY_MAX)
      wgrp.tmin = DLY_MAX;
  end

  // Active group and slope arithmetic
  // Tmin above top is treated as top, which keeps definite time
  // Trip product fits 17 bits: 100 times 1000 ticks at most
  always_comb
  begin
    cur = r.set[r.grp];
    top_t = 10'(cur.top) * DLY_TICK_MUL;
    tmin_t = 10'(cur.tmin) * DLY_TICK_MUL;
    if (tmin_t > top_t)
      tmin_t = top_t;
    delta = {1'b0, freq_mhz} - {1'b0, r.prev_freq};
    mag = delta[17] ? 17'(-delta) : delta[16:0];
    above = r.have_prev && (mag > 17'(cur.thr));
    acc = {1'b0, freq_mhz} - {1'b0, r.start_freq};
    acc_mag = acc[17] ? 17'(-acc) : acc[16:0];
    lim = 17'(cur.thr) * 17'(top_t);
    n_inc = r.n + 11'h001;
    // Trip window from minimum delay to operate delay
    trip_ok = (n_inc >= {1'b0, tmin_t})
      && (n_inc <= {1'b0, top_t})
      && (acc_mag > lim);
  end

  // Next-state logic
  // Register writes, strobes, stage sequence and latches in one pass
  // Later sections see earlier ones through next_r, so order matters
  always_comb
  begin
    next_r = r;
    next_r.eval_tick = 1'b0;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    rel = release_req;
    // Free-running interval counter, restarted only by reset
    tick = r.tick_cnt == 17'(TICK_CYCLES - 1);
    next_r.tick_cnt = tick ? 17'h0_0000 : r.tick_cnt + 17'h0_0001;

    // Register writes
    if (wr && mapped)
    begin
      // STATUS is read-only; its branch only keeps the group
      case (apb_req.paddr)
        OFS_CTRL:
        begin
          next_r.grp = apb_req.pwdata[CTRL_GRP +: 2];
          next_r.eval_sel = apb_req.pwdata[CTRL_EVAL +: 2];
          next_r.latch_en = apb_req.pwdata[CTRL_LATCH +: 2];
          next_r.store_en = apb_req.pwdata[CTRL_STORE];
          rel = rel || apb_req.pwdata[CTRL_REL];
        end
        OFS_PROG:
        begin
          next_r.mode = rcf_mode_e'(apb_req.pwdata[PROG_MODE +: 2]);
          next_r.sel_a = apb_req.pwdata[PROG_SEL_A +: 5];
          next_r.sel_b = apb_req.pwdata[PROG_SEL_B +: 5];
        end
        OFS_STATUS:
        begin
          next_r.grp = r.grp;
        end
        default:
        begin
          next_r.set[apb_req.paddr[3:2]] = wgrp;
        end
      endcase
    end

    // Read data captured in the setup cycle
    // Holds through the access phase, so a late decode cannot glitch
    if (apb_req.psel && !apb_req.penable)
      next_r.prdata = rd;

    // Evaluation strobe for the programmable stages
    // A shrunk divider wraps at once rather than waiting a lap
    case (r.eval_sel)
      2'h0: div = EVAL_DIV_S;
      2'h1: div = EVAL_DIV_M;
      default: div = EVAL_DIV_L;
    endcase
    if (tick)
    begin
      if (r.eval_cnt + 4'h1 >= div)
      begin
        next_r.eval_cnt = 4'h0;
        next_r.eval_tick = 1'b1;
      end
      else
        next_r.eval_cnt = r.eval_cnt + 4'h1;
    end

    // Stage sequence, once per measurement interval
    // Between ticks the sequence holds, only bus writes and blocking act
    if (tick)
    begin
      next_r.prev_freq = freq_mhz;
      next_r.have_prev = 1'b1;
      case (r.st)
        ST_IDLE, ST_ARM:
        begin
          if (above)
          begin
            next_r.st = ST_ARM;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt + 4'h1 == PICKUP_TICKS)
            begin
              next_r.st = ST_RUN;
              next_r.start_freq = freq_mhz;
              next_r.n = 11'h000;
              next_r.cnt = 4'h0;
            end
          end
          else
          begin
            next_r.st = ST_IDLE;
            next_r.cnt = 4'h0;
          end
        end
        ST_RUN:
        begin
          // Slope dips do not release; average keeps running
          next_r.n = n_inc;
          if (n_inc == 11'(START_TICKS))
            next_r.start_out = 1'b1;
          if (trip_ok)
            next_r.trip = 1'b1;
          if (n_inc > {1'b0, top_t})
          begin
            next_r.st = ST_DONE;
            next_r.cnt = 4'h0;
          end
        end
        ST_DONE:
        begin
          if (above)
            next_r.cnt = 4'h0;
          else
          begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt + 4'h1 == STABLE_TICKS)
            begin
              next_r.st = ST_IDLE;
              next_r.start_out = 1'b0;
              next_r.trip = 1'b0;
              next_r.cnt = 4'h0;
            end
          end
        end
        default:
        begin
          next_r.st = ST_IDLE;
        end
      endcase
    end

    // Blocking or group change abandons any running sequence
    // Applied after the sequence, so it overrides a same-tick trip
    clr = lv_block || (next_r.grp != r.grp);
    if (clr)
    begin
      next_r.st = ST_IDLE;
      next_r.cnt = 4'h0;
      next_r.n = 11'h000;
      next_r.start_freq = 17'h0_0000;
      next_r.start_out = 1'b0;
      next_r.trip = 1'b0;
    end

    // Latches: restore once after restart, then set wins over release
    // Kept copy tracks the latches only while storage is enabled
    if (r.restore)
    begin
      next_r.restore = 1'b0;
      next_r.latched = r.store_en ? r.kept : 2'h0;
    end

    // Live bits come after clearing, so blocking drops them
    live = {next_r.trip, next_r.start_out};
    for (int i = 0; i < 2; i++)
    begin
      if (r.latch_en[i] && live[i])
        next_r.latched[i] = 1'b1;
      else if (rel)
        next_r.latched[i] = 1'b0;
    end

    // Copy and contacts from the final latch value
    next_r.kept = next_r.store_en ? next_r.latched : 2'h0;
    next_r.contacts = live | next_r.latched;
  end

  // State register; restart keeps the stored latch copy
  // Power-on clear drops the copy as well
  always_ff @(posedge clk)
  begin
    if (por)
      r <= REGS_RST;
    else if (rst)
    begin
      r <= REGS_RST;
      r.store_en <= r.store_en;
      r.kept <= r.kept;
    end
    else
      r <= next_r;
  end

  // Bus response; no wait states, error only in the access phase
  assign apb_rsp = '{
    prdata: r.prdata,
    pready: 1'b1,
    pslverr: apb_req.psel && apb_req.penable && !mapped
  };

  // Stage and programmable-stage outputs
  assign output_contacts = r.contacts;
  assign eval_tick = r.eval_tick;
  assign prog_mode = r.mode;
  assign prog_sel_a = r.sel_a;
  assign prog_sel_b = diff_mode ? r.sel_b : 5'h00;

endmodule
`default_nettype wire

// file: rcf_stage_props.sv
/*
  Port checker for the rate-of-change-of-frequency stage.
  Assumes one clock; rst and por are synchronous and active high.
*/
`timescale 1ns/10ps
`default_nettype none
module rcf_stage_props
  import rcf_pkg::*;
#(
  parameter int TICK_CYCLES = rcf_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire rcf_pkg::rcf_apb_req_s apb_req,
  input wire rcf_pkg::rcf_apb_rsp_s apb_rsp,
  input wire logic [16:0] freq_mhz,
  input wire logic lv_block,
  input wire logic release_req,
  input wire logic [1:0] output_contacts,
  input wire logic eval_tick,
  input wire rcf_pkg::rcf_mode_e prog_mode,
  input wire logic [4:0] prog_sel_a,
  input wire logic [4:0] prog_sel_b
);
  logic [31:0] quiet;
  logic mapped;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || por);

  // Cycles since the last reset, power-on clear or blocking
  always_ff @(posedge clk)
  begin
    if (rst || por || lv_block)
      quiet <= '0;
    else
      quiet <= quiet + 32'h1;
  end

  // Aligned words that hold a register
  assign mapped = apb_req.paddr[1:0] == 2'h0 && (apb_req.paddr <= OFS_PROG
    || (apb_req.paddr >= 8'h10 && apb_req.paddr <= 8'h1C));

  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  chk_ready_high: assert property (s_access |-> apb_rsp.pready)
    else $error("pready low in access");
  chk_bad_addr: assert property (s_access ##0 !mapped |-> apb_rsp.pslverr)
    else $error("no error on unmapped access");
  chk_good_addr: assert property (s_access ##0 mapped |-> !apb_rsp.pslverr)
    else $error("error on mapped access");
  chk_sel_b_zero: assert property (
    prog_mode inside {PM_OVER, PM_UNDER} |-> prog_sel_b == 5'h00)
    else $error("second select shown outside difference modes");
  chk_eval_gap: assert property (
    $rose(eval_tick) |=> !eval_tick [*8])
    else $error("evaluation pulses too close");
  chk_lv_rise: assert property (
    $rose(output_contacts[1]) |-> !$past(lv_block))
    else $error("trip rose while blocked");
  chk_start_delay: assert property (
    $rose(output_contacts[0]) && !$past(rst) && !$past(rst, 2)
      && !$past(rst, 3) |-> quiet >= 13 * TICK_CYCLES)
    else $error("start too early");
  chk_por_clear: assert property (
    @(posedge clk) disable iff (rst)
    por |=> output_contacts == 2'h0 && !eval_tick)
    else $error("outputs not cleared by power-on clear");
endmodule
bind rcf_stage rcf_stage_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk, .rst, .por, .apb_req, .apb_rsp, .freq_mhz, .lv_block,
  .release_req, .output_contacts, .eval_tick, .prog_mode, .prog_sel_a,
  .prog_sel_b
);
`default_nettype wire

// file: rcf_freq_src.sv
/*
  Frequency front end model: moves the measured frequency by one step
  per interval. Assumes the stage samples once per TICK clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module rcf_freq_src #(
  parameter int TICK = 20
) (
  input wire logic clk,
  input wire logic [7:0] step,
  input wire logic down,
  output var logic [16:0] freq
);
  int cnt = 0;

  initial freq = 17'hC350;

  // One frequency step per interval, either direction
  always @(posedge clk)
  begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    if (cnt == 0)
      freq <= down ? freq - 17'(step) : freq + 17'(step);
  end
endmodule
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench for rcf_stage: APB tasks and timed slope faults.
  Assumes a 20-clock measurement interval set through TICK_CYCLES.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rcf_pkg::*;
  localparam int TICK = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic lv = 1'b0;
  logic rel = 1'b0;
  logic down = 1'b0;
  logic [7:0] step = 8'h00;
  logic [16:0] freq;
  rcf_apb_req_s req = '0;
  rcf_apb_rsp_s rsp;
  logic [1:0] contacts;
  logic etick;
  rcf_mode_e pmode;
  logic [4:0] psb;
  logic [4:0] psa;
  logic slv;
  int cyc = 0;
  int t0 = 0;
  int err_total = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  rcf_freq_src #(.TICK(TICK)) u_src (
    .clk(clk), .step(step), .down(down), .freq(freq)
  );
  rcf_stage #(.TICK_CYCLES(TICK)) u_dut (
    .clk(clk), .rst(rst), .por(por), .apb_req(req), .apb_rsp(rsp),
    .freq_mhz(freq), .lv_block(lv), .release_req(rel),
    .output_contacts(contacts), .eval_tick(etick), .prog_mode(pmode),
    .prog_sel_a(psa), .prog_sel_b(psb)
  );

  task automatic tally_and_finish;
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cycle count and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    slv = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    cmp(q, exp);
  endtask

  task automatic wait_tick;
    do @(negedge clk); while (etick !== 1'b1);
  endtask

  // Block the stage, optionally pulsing the panel release
  task automatic clear_stage(input logic r);
    @(posedge clk);
    step <= 8'h00;
    lv <= 1'b1;
    rel <= r;
    @(posedge clk);
    rel <= 1'b0;
    @(posedge clk);
    lv <= 1'b0;
    @(negedge clk);
  endtask

  // Ramp the frequency and note when start appears
  task automatic ramp(input logic [7:0] s, input logic dn);
    @(posedge clk);
    step <= s;
    down <= dn;
    do @(negedge clk); while (contacts[0] !== 1'b1);
    t0 = cyc;
  endtask

  task automatic trip_after(input int exp);
    do @(negedge clk); while (contacts[1] !== 1'b1);
    cmp(32'((cyc - t0) / TICK), 32'(exp));
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(8'h10, 32'h01E01E05);
    rd(8'h0C, 32'h0);
    cmp(32'(slv), 32'h1);
    wr(8'h14, 32'h0001FF7F);
    rd(8'h14, 32'h0001F464);
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_PROG, 32'h48C | 32'(m));
      @(negedge clk);
      cmp(32'({pmode, psb}), 32'({2'(m), m > 1 ? 5'h09 : 5'h00}));
      cmp(32'(psa), 32'h3);
    end
    for (int e = 0; e < 3; e++)
    begin
      wr(OFS_CTRL, 32'(e) << CTRL_EVAL);
      repeat (2) wait_tick();
      t0 = cyc;
      wait_tick();
      cmp(32'(cyc - t0), 32'(TICK * (e == 2 ? 10 : e + 1)));
    end
    wr(OFS_CTRL, 32'h20);
    ramp(8'h06, 1'b0);
    trip_after(54);
    wr(OFS_CTRL, 32'h60);
    @(posedge clk);
    step <= 8'h00;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    cmp(32'(contacts), 32'h2);
    rd(OFS_STATUS, 32'h20);
    clear_stage(1'b0);
    cmp(32'(contacts), 32'h2);
    wr(OFS_CTRL, 32'hA0);
    @(negedge clk);
    cmp(32'(contacts), 32'h0);
    wr(8'h10, 32'h00701E05);
    ramp(8'h14, 1'b1);
    trip_after(10);
    clear_stage(1'b1);
    cmp(32'(contacts), 32'h0);
    ramp(8'h28, 1'b0);
    trip_after(8);
    clear_stage(1'b1);
    wr(8'h10, 32'h01E01E05);
    ramp(8'h06, 1'b0);
    @(posedge clk);
    step <= 8'h00;
    do @(negedge clk); while (contacts[0] !== 1'b0);
    cmp(32'(contacts), 32'h0);
    cmp(32'((cyc - t0) / TICK > 54), 32'h1);
    ramp(8'h06, 1'b0);
    wr(OFS_CTRL, 32'h21);
    @(negedge clk);
    cmp(32'(contacts), 32'h0);
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
